// >>> src/atcp_pkg.sv
// Constants and types for the asynchronous timer clock block.
// Assumes a 32-bit classic Wishbone slave port and a 10 MHz clk.
package atcp_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_COUNTER = 8'h00;
    localparam logic [7:0] OFS_COMPARE = 8'h04;
    localparam logic [7:0] OFS_CONTROL = 8'h08;
    localparam logic [7:0] OFS_STATUS  = 8'h0c;
    localparam logic [7:0] OFS_GENERAL = 8'h10;
    localparam logic [7:0] OFS_FLAGS   = 8'h14;
    localparam logic [7:0] OFS_ENABLE  = 8'h18;

    // Holding register index, equal to its busy bit in status
    localparam int HOLD_CTRL = 0;
    localparam int HOLD_CMP  = 1;
    localparam int HOLD_CNT  = 2;
    localparam int ST_ASYNC  = 3;
    localparam int ST_EXT    = 4;

    localparam int GEN_PSR  = 0;
    localparam int FLG_OVF  = 0;
    localparam int FLG_CMP  = 1;
    localparam int CTL_CS   = 0;
    localparam int CTL_COM  = 4;

    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [7:0] CNT_MAX  = 8'hff;

    // Oscillator edges before a held value lands
    localparam logic [1:0] XFER_EDGES = 2'd2;
    // Processor cycles of interrupt flag synchronisation
    localparam int FLAG_SYNC_CYCLES = 3;

    localparam int PSC_W = 10;
    localparam int DIV_8    = 8;
    localparam int DIV_32   = 32;
    localparam int DIV_64   = 64;
    localparam int DIV_128  = 128;
    localparam int DIV_256  = 256;
    localparam int DIV_1024 = 1024;

    typedef enum logic [2:0] {
        CS_STOP, CS_DIV1, CS_DIV8, CS_DIV32,
        CS_DIV64, CS_DIV128, CS_DIV256, CS_DIV1024
    } atcp_clksel_t;

    typedef enum logic [2:0] {
        SLP_ACTIVE, SLP_IDLE, SLP_ADC_NR,
        SLP_POWER_DOWN, SLP_POWER_SAVE, SLP_STANDBY
    } atcp_sleep_t;

    typedef struct packed {
        logic ext_clock_select;
        logic async_select;
        logic counter_update_busy;
        logic compare_update_busy;
        logic control_update_busy;
    } atcp_status_t;
endpackage

// >>> src/atcp_prescaler.sv
// Timer prescaler: divides source ticks into the selected count rate.
// Assumes src_tick is a one-cycle enable in the clk domain.
`timescale 1ns/1ps
module atcp_prescaler (
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic                  src_tick,
    input  wire logic                  clear,
    input  wire atcp_pkg::atcp_clksel_t sel,
    output logic                       tick
);
    import atcp_pkg::*;

    logic [PSC_W-1:0] count;

    function automatic logic [PSC_W-1:0] div_mask(input atcp_clksel_t s);
        unique case (s)
            CS_DIV8:    div_mask = PSC_W'(DIV_8 - 1);
            CS_DIV32:   div_mask = PSC_W'(DIV_32 - 1);
            CS_DIV64:   div_mask = PSC_W'(DIV_64 - 1);
            CS_DIV128:  div_mask = PSC_W'(DIV_128 - 1);
            CS_DIV256:  div_mask = PSC_W'(DIV_256 - 1);
            CS_DIV1024: div_mask = PSC_W'(DIV_1024 - 1);
            CS_STOP,
            CS_DIV1:    div_mask = '0;
        endcase
    endfunction

    always_ff @(posedge clk) begin
        if (!resetn || clear) begin
            count <= '0;
        end else if (src_tick) begin
            count <= count + 1'b1;
        end
    end

    // Stop, undivided, or one tick per full divider period
    always_comb begin
        if (sel == CS_STOP) begin
            tick = 1'b0;
        end else begin
            tick = src_tick && ((count & div_mask(sel)) == div_mask(sel));
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    psc_clear_a: assert property (clear |=> count == '0)
        else $error("prescaler not cleared");
    div8_period_a: assert property (sel == CS_DIV8 && tick && !clear
        |-> count[2:0] == 3'h7)
        else $error("div8 tick off phase");
endmodule

// >>> src/atcp_timer.sv
// Asynchronous timer with write holding registers and prescaler.
// Assumes a classic Wishbone master and osc_in_pin from outside clk.
// Operation
// - Async writes land after two oscillator edges
// - Each synced register has own holding register
// - Busy flags show pending transfers
// - Compare match suppressed while compare or counter writes pending
// - Wake logic needs one oscillator cycle reset
// - Wake-up starts on next timer cycle
// - Counter read via shadow refreshed per edge
// - Flag sync takes three cycles plus tick
// - Compare output changes on timer clock
// - Source clock io, oscillator when async
// - Async releases oscillator pins from port
// - Prescaler offers stop, 1 and dividers
// - Prescaler reset bit clears prescaler
// - Oscillator runs only when async, except in power-down, standby
`timescale 1ns/1ps
module atcp_timer (
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic                 osc_in_pin,
    input  wire atcp_pkg::atcp_sleep_t sleep_mode,
    output logic                      compare_out_pin,
    output logic                      wake_req,
    output logic                      osc_enable,
    output logic                      osc_drive_en,
    output logic                      port_release
);
    import atcp_pkg::*;

    logic       osc_meta;
    logic       osc_sync;
    logic       osc_prev;
    logic       osc_rise;
    logic       async_select;
    logic       ext_clock_select;
    logic       psc_clear;
    logic       src_tick;
    logic       tick;
    logic       req;
    logic       wr_lane;
    logic [2:0] wr;
    logic [2:0] busy;
    logic [2:0] xfer;
    logic [7:0] hold [3];
    logic [1:0] edges [3];
    logic [7:0] timer_control;
    logic [7:0] compare_value;
    logic [7:0] counter_value;
    logic [7:0] counter_shadow;
    logic       block_next;
    logic       match_now;
    logic       ovf_now;
    logic [1:0] flags;
    logic [1:0] irq_en;
    logic [1:0] pipe0;
    logic [1:0] pipe1;
    logic [1:0] ev;
    logic       io_stopped;
    logic       wake_sleep;
    logic       wake_pending;
    logic       wake_armed;
    logic       wake_rearm;
    atcp_status_t status;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr[7:2] == ofs[7:2]);
    endfunction

    // Oscillator pin synchroniser and edge detect
    always_ff @(posedge clk) begin
        if (!resetn) begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_prev <= 1'b0;
        end else begin
            osc_meta <= osc_in_pin;
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    assign osc_rise = osc_sync && !osc_prev;
    assign src_tick = async_select ? osc_rise : 1'b1;

    // Wishbone slave, one wait state
    assign req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_lane = req && wb_we_i && wb_sel_i[0];

    always_comb begin
        wr[HOLD_CTRL] = wr_lane && hit(wb_adr_i, OFS_CONTROL);
        wr[HOLD_CMP]  = wr_lane && hit(wb_adr_i, OFS_COMPARE);
        wr[HOLD_CNT]  = wr_lane && hit(wb_adr_i, OFS_COUNTER);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    always_comb begin
        status.ext_clock_select    = ext_clock_select;
        status.async_select        = async_select;
        status.counter_update_busy = busy[HOLD_CNT];
        status.compare_update_busy = busy[HOLD_CMP];
        status.control_update_busy = busy[HOLD_CTRL];
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wb_dat_o <= '0;
        end else if (req && !wb_we_i) begin
            wb_dat_o <= '0;
            if (hit(wb_adr_i, OFS_COUNTER)) begin
                wb_dat_o[7:0] <= counter_shadow;
            end else if (hit(wb_adr_i, OFS_COMPARE)) begin
                wb_dat_o[7:0] <= compare_value;
            end else if (hit(wb_adr_i, OFS_CONTROL)) begin
                wb_dat_o[7:0] <= timer_control;
            end else if (hit(wb_adr_i, OFS_STATUS)) begin
                wb_dat_o[4:0] <= status;
            end else if (hit(wb_adr_i, OFS_FLAGS)) begin
                wb_dat_o[1:0] <= flags;
            end else if (hit(wb_adr_i, OFS_ENABLE)) begin
                wb_dat_o[1:0] <= irq_en;
            end
        end
    end

    // Clock source selection bits, written directly
    always_ff @(posedge clk) begin
        if (!resetn) begin
            async_select     <= 1'b0;
            ext_clock_select <= 1'b0;
        end else if (wr_lane && hit(wb_adr_i, OFS_STATUS)) begin
            async_select     <= wb_dat_i[ST_ASYNC];
            ext_clock_select <= wb_dat_i[ST_EXT];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            irq_en <= '0;
        end else if (wr_lane && hit(wb_adr_i, OFS_ENABLE)) begin
            irq_en <= wb_dat_i[1:0];
        end
    end

    // Prescaler reset is a self-clearing strobe
    always_ff @(posedge clk) begin
        if (!resetn) begin
            psc_clear <= 1'b0;
        end else begin
            psc_clear <= wr_lane && hit(wb_adr_i, OFS_GENERAL) && wb_dat_i[GEN_PSR];
        end
    end

    atcp_prescaler u_psc (
        .clk      (clk),
        .resetn   (resetn),
        .src_tick (src_tick),
        .clear    (psc_clear),
        .sel      (atcp_clksel_t'(timer_control[CTL_CS +: 3])),
        .tick     (tick)
    );

    // Independent holding registers with transfer on second edge when async, next cycle otherwise
    for (genvar i = 0; i < 3; i++) begin : g_hold
        assign xfer[i] = busy[i] && (!async_select ||
                         (osc_rise && edges[i] == XFER_EDGES - 2'd1));

        always_ff @(posedge clk) begin
            if (!resetn) begin
                hold[i]  <= RST_REG8;
                busy[i]  <= 1'b0;
                edges[i] <= '0;
            end else if (wr[i]) begin
                hold[i]  <= wb_dat_i[7:0];
                busy[i]  <= 1'b1;
                edges[i] <= '0;
            end else if (xfer[i]) begin
                busy[i]  <= 1'b0;
            end else if (busy[i] && osc_rise) begin
                edges[i] <= edges[i] + 2'd1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            timer_control <= RST_REG8;
        end else if (xfer[HOLD_CTRL]) begin
            timer_control <= hold[HOLD_CTRL];
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            compare_value <= RST_REG8;
        end else if (xfer[HOLD_CMP]) begin
            compare_value <= hold[HOLD_CMP];
        end
    end

    // Counter; a loaded value blocks the next match
    always_ff @(posedge clk) begin
        if (!resetn) begin
            counter_value <= RST_REG8;
            block_next    <= 1'b0;
        end else if (xfer[HOLD_CNT]) begin
            counter_value <= hold[HOLD_CNT];
            block_next    <= 1'b1;
        end else if (tick) begin
            counter_value <= counter_value + 8'h01;
            block_next    <= 1'b0;
        end
    end

    assign match_now = tick && counter_value == compare_value && !block_next &&
                       !busy[HOLD_CMP] && !busy[HOLD_CNT];
    assign ovf_now   = tick && counter_value == CNT_MAX;
    assign ev        = {match_now, ovf_now};

    // Compare output driven straight from the timer tick
    always_ff @(posedge clk) begin
        if (!resetn) begin
            compare_out_pin <= 1'b0;
        end else if (match_now) begin
            unique case (timer_control[CTL_COM +: 2])
                2'h1: compare_out_pin <= !compare_out_pin;
                2'h2: compare_out_pin <= 1'b0;
                2'h3: compare_out_pin <= 1'b1;
                2'h0: compare_out_pin <= compare_out_pin;
            endcase
        end
    end

    // Shadow for counter reads; frozen while io clock is off
    assign io_stopped = sleep_mode inside {SLP_ADC_NR, SLP_POWER_DOWN,
                                           SLP_POWER_SAVE, SLP_STANDBY};

    always_ff @(posedge clk) begin
        if (!resetn) begin
            counter_shadow <= RST_REG8;
        end else if (!io_stopped && (!async_select || osc_rise)) begin
            counter_shadow <= counter_value;
        end
    end

    // Flag synchroniser into processor domain
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pipe0 <= '0;
            pipe1 <= '0;
        end else begin
            pipe0 <= async_select ? ev : 2'b00;
            pipe1 <= pipe0;
        end
    end

    // Write one to clear; a set in the same cycle wins
    always_ff @(posedge clk) begin
        if (!resetn) begin
            flags <= '0;
        end else begin
            for (int k = 0; k < 2; k++) begin
                if ((async_select && pipe1[k]) || (!async_select && ev[k])) begin
                    flags[k] <= 1'b1;
                end else if (wr_lane && hit(wb_adr_i, OFS_FLAGS) && wb_dat_i[k]) begin
                    flags[k] <= 1'b0;
                end
            end
        end
    end

    // Wake-up from timed sleep
    assign wake_sleep = async_select &&
                        (sleep_mode == SLP_POWER_SAVE || sleep_mode == SLP_ADC_NR);

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wake_pending <= 1'b0;
            wake_req     <= 1'b0;
        end else begin
            wake_req <= 1'b0;
            if (wake_pending && osc_rise) begin
                wake_pending <= 1'b0;
                wake_req     <= 1'b1;
            end else if (wake_sleep && wake_armed && |(ev & irq_en)) begin
                wake_pending <= 1'b1;
            end
        end
    end

    // Rearm only after one full oscillator cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wake_armed <= 1'b1;
            wake_rearm <= 1'b0;
        end else if (wake_req) begin
            wake_armed <= 1'b0;
            wake_rearm <= 1'b1;
        end else if (wake_rearm && osc_rise) begin
            wake_armed <= 1'b1;
            wake_rearm <= 1'b0;
        end
    end

    // Oscillator and pin control
    always_ff @(posedge clk) begin
        if (!resetn) begin
            osc_enable   <= 1'b0;
            osc_drive_en <= 1'b0;
            port_release <= 1'b0;
        end else begin
            osc_enable   <= async_select && sleep_mode != SLP_POWER_DOWN &&
                            sleep_mode != SLP_STANDBY;
            osc_drive_en <= async_select && !ext_clock_select &&
                            sleep_mode != SLP_POWER_DOWN && sleep_mode != SLP_STANDBY;
            port_release <= async_select;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    xfer_wait_a: assert property (
        async_select && busy[HOLD_CNT] && !wr[HOLD_CNT] && edges[HOLD_CNT] == 2'd0
        && osc_rise |=> busy[HOLD_CNT])
        else $error("counter write landed after one edge");
    xfer_edge_a: assert property (
        async_select && $fell(busy[HOLD_CMP]) |-> $past(osc_rise))
        else $error("compare landed without oscillator edge");
    hold_indep_a: assert property (
        wr[HOLD_CTRL] && busy[HOLD_CMP] && !async_select |=> $stable(hold[HOLD_CMP]))
        else $error("control write disturbed compare hold");
    busy_set_a: assert property (wr[HOLD_CNT] |=> busy[HOLD_CNT])
        else $error("busy flag not raised");
    cmp_suppress_a: assert property (
        busy[HOLD_CMP] || busy[HOLD_CNT] |-> !match_now)
        else $error("match while write pending");
    wake_rearm_a: assert property (wake_req |=> !wake_armed ##0 !wake_req)
        else $error("wake logic not reset");
    wake_edge_a: assert property (wake_req |-> $past(osc_rise))
        else $error("wake not on timer cycle");
    shadow_hold_a: assert property (
        async_select && !osc_rise |=> $stable(counter_shadow))
        else $error("shadow changed between edges");
    flag_sync_a: assert property (
        async_select && match_now |-> ##3 flags[FLG_CMP])
        else $error("compare flag not synchronised in three cycles");
    cmp_out_a: assert property (!$stable(compare_out_pin) |-> $past(tick))
        else $error("compare output moved off timer tick");
    src_sync_a: assert property (!async_select |-> src_tick)
        else $error("io clock not source");
    pin_rel_a: assert property (async_select |=> port_release)
        else $error("pins not released");
    osc_run_a: assert property (
        async_select && sleep_mode == SLP_POWER_SAVE |=> osc_enable)
        else $error("oscillator stopped in power-save");

    cover_async_xfer: cover property (async_select && xfer[HOLD_CNT]);
    cover_wake: cover property (wake_req);
    cover_cmp_flag: cover property (async_select && $rose(flags[FLG_CMP]));
endmodule

// >>> testbench/atcp_osc_model.sv
// Model of the low-frequency clock source on osc_in_pin.
// Assumes enable follows the block's oscillator enable output.
`timescale 1ns/1ps
module atcp_osc_model #(
    parameter int HALF_NS = 700
) (
    input  wire logic enable,
    output logic      osc
);
    initial osc = 1'b0;
    // Period 14 clk, well above four clk periods
    // Halted and low while the oscillator is off
    // Runs as soon as enabled, with no settling wait
    always begin
        #HALF_NS;
        if (enable === 1'b1) begin
            osc = ~osc;
        end else begin
            osc = 1'b0;
        end
    end
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the asynchronous timer block.
// Assumes the block answers Wishbone accesses and osc_in_pin from a model.
`timescale 1ns/1ps
module tb;
    import atcp_pkg::*;
    typedef struct packed {
        logic [7:0] adr;
        logic       wr;
        logic [7:0] wd;
        logic [7:0] exp;
    } atcp_row_t;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat = 32'h0;
    logic [31:0] dat_o;
    logic        ack, osc, cmp_out, wake, osc_en, drive_en, rel;
    logic [7:0]  q, r2;
    atcp_sleep_t sleep = SLP_ACTIVE;
    int          err_total = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          rises = 0;
    int          wakes = 0;
    int          n0, d, w, lo, hi;
    atcp_row_t   rows [8] = '{'{OFS_COMPARE, 1'b1, 8'h5a, 8'h5a}, '{OFS_CONTROL, 1'b1, 8'h30, 8'h30},
                              '{OFS_ENABLE, 1'b1, 8'h03, 8'h03}, '{OFS_GENERAL, 1'b1, 8'h01, 8'h00},
                              '{8'h1c, 1'b1, 8'hff, 8'h00}, '{OFS_STATUS, 1'b0, 8'h00, 8'h00},
                              '{OFS_ENABLE, 1'b1, 8'h00, 8'h00}, '{OFS_FLAGS, 1'b0, 8'h00, 8'h00}};
    int          divs [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};

    always #50 clk = ~clk;

    atcp_timer atcp_timer_i (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .osc_in_pin(osc), .sleep_mode(sleep), .compare_out_pin(cmp_out),
        .wake_req(wake), .osc_enable(osc_en), .osc_drive_en(drive_en), .port_release(rel));
    atcp_osc_model atcp_osc_model_i (.enable(osc_en), .osc(osc));

    always @(posedge osc) rises++;
    always @(posedge clk) begin
        if (wake === 1'b1) wakes++;
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            $display("[FAIL] timeout after %0d cycles", cycles);
            summarize();
        end
    end

    task automatic summarize();
        $display("checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Classic single Wishbone cycle, held until ack
    task automatic bus(input logic w_en, input logic [7:0] a, input logic [7:0] wd,
                       output logic [7:0] rd);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w_en;
        adr <= a;
        dat <= {24'h0, wd};
        sel <= 4'h1;
        do @(posedge clk); while (ack !== 1'b1);
        rd = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wait_busy();
        logic [7:0] s;
        for (int k = 0; k < 60; k++) begin
            bus(1'b0, OFS_STATUS, 8'h00, s);
            if (s[2:0] === 3'b000) break;
        end
        check("busy clear", {29'h0, s[2:0]}, 32'h0);
    endtask

    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].wr) bus(1'b1, rows[i].adr, rows[i].wd, q);
            bus(1'b0, rows[i].adr, 8'h00, q);
            check("row read", {24'h0, q}, {24'h0, rows[i].exp});
        end
        // Second reset in mid-run
        @(posedge clk);
        resetn <= 1'b0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        check("outputs", {27'h0, cmp_out, wake, osc_en, drive_en, rel}, 32'h0);
        bus(1'b0, OFS_COMPARE, 8'h00, q);
        check("compare rst", {24'h0, q}, 32'h0);
        // Every clock select, after a prescaler reset
        foreach (divs[i]) begin
            d = divs[i];
            w = (d > 1) ? 4 * d : 32;
            lo = (d == 0) ? 0 : w / d - ((d > 1) ? 1 : 2);
            hi = (d == 0) ? 0 : w / d + ((d > 1) ? 1 : 6);
            bus(1'b1, OFS_CONTROL, 8'h00, q);
            bus(1'b1, OFS_COUNTER, 8'h00, q);
            bus(1'b1, OFS_GENERAL, 8'h01, q);
            bus(1'b1, OFS_CONTROL, i[7:0], q);
            repeat (w) @(posedge clk);
            bus(1'b0, OFS_COUNTER, 8'h00, q);
            check("div count", {31'h0, (q >= lo && q <= hi)}, 32'h1);
        end
        // Prescaler phase becomes predictable after reset
        repeat (600) @(posedge clk);
        bus(1'b1, OFS_COUNTER, 8'h00, q);
        bus(1'b1, OFS_GENERAL, 8'h01, q);
        repeat (990) @(posedge clk);
        bus(1'b0, OFS_COUNTER, 8'h00, q);
        check("psr early", {24'h0, q}, 32'h0);
        repeat (60) @(posedge clk);
        bus(1'b0, OFS_COUNTER, 8'h00, q);
        check("psr tick", {24'h0, q}, 32'h1);
        // Toggle on match in sync mode
        bus(1'b1, OFS_CONTROL, 8'h00, q);
        bus(1'b1, OFS_FLAGS, 8'h03, q);
        bus(1'b1, OFS_COUNTER, 8'h00, q);
        bus(1'b1, OFS_COMPARE, 8'h05, q);
        bus(1'b1, OFS_CONTROL, 8'h11, q);
        repeat (20) @(posedge clk);
        check("cmp pin", {31'h0, cmp_out}, 32'h1);
        bus(1'b0, OFS_FLAGS, 8'h00, q);
        check("match flag", {24'h0, q}, 32'h2);
        // Switch to the external clock source
        bus(1'b1, OFS_CONTROL, 8'h00, q);
        bus(1'b1, OFS_STATUS, 8'h18, q);
        repeat (4) @(posedge clk);
        check("pins", {29'h0, rel, osc_en, drive_en}, 32'h6);
        bus(1'b1, OFS_CONTROL, 8'h00, q);
        bus(1'b1, OFS_COUNTER, 8'h40, q);
        bus(1'b1, OFS_COMPARE, 8'h60, q);
        n0 = rises;
        bus(1'b0, OFS_STATUS, 8'h00, q);
        check("all busy", {24'h0, q}, 32'h1f);
        wait_busy();
        check("two edges", {31'h0, (rises - n0 >= 2)}, 32'h1);
        repeat (30) @(posedge clk);
        bus(1'b0, OFS_COUNTER, 8'h00, q);
        check("cnt landed", {24'h0, q}, 32'h40);
        bus(1'b0, OFS_COMPARE, 8'h00, q);
        check("cmp landed", {24'h0, q}, 32'h60);
        bus(1'b1, OFS_FLAGS, 8'h03, q);
        bus(1'b1, OFS_CONTROL, 8'h01, q);
        wait_busy();
        // Shadow frozen in sleep, refreshed on the next edge
        sleep <= SLP_POWER_SAVE;
        bus(1'b0, OFS_COUNTER, 8'h00, q);
        repeat (60) @(posedge clk);
        bus(1'b0, OFS_COUNTER, 8'h00, r2);
        check("frozen", {24'h0, r2}, {24'h0, q});
        sleep <= SLP_ACTIVE;
        repeat (30) @(posedge clk);
        bus(1'b0, OFS_COUNTER, 8'h00, q);
        check("refreshed", {31'h0, (q !== r2)}, 32'h1);
        // Wake on compare match in power-save
        bus(1'b1, OFS_ENABLE, 8'h02, q);
        bus(1'b1, OFS_COMPARE, q + 8'h08, q);
        wait_busy();
        wakes = 0;
        sleep <= SLP_POWER_SAVE;
        repeat (300) @(posedge clk);
        sleep <= SLP_ACTIVE;
        check("wake count", wakes, 32'h1);
        bus(1'b0, OFS_FLAGS, 8'h00, q);
        check("async flag", {31'h0, q[FLG_CMP]}, 32'h1);
        for (int m = 0; m < 6; m++) begin
            sleep <= atcp_sleep_t'(m);
            repeat (4) @(posedge clk);
            check("osc run", {31'h0, osc_en}, {31'h0, (m != 3 && m != 5)});
        end
        summarize();
    end
endmodule
